/* File: verilog/arh_pkg.sv */
// package: constants for the automatic rate handshake uart block
package arh_pkg;
  // -----------------------------------------------------------------
  // clock and rates
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100000000;
  localparam int          NUM_RATES   = 8;
  localparam int          DIV_W       = 16;
  // bit times in clock cycles, slowest first: 9600 ... 921600 bps
  localparam logic [DIV_W-1:0] RATE_DIV [NUM_RATES] = '{
    16'(CLK_HZ / 9600),   16'(CLK_HZ / 19200),  16'(CLK_HZ / 38400),
    16'(CLK_HZ / 57600),  16'(CLK_HZ / 115200), 16'(CLK_HZ / 230400),
    16'(CLK_HZ / 460800), 16'(CLK_HZ / 921600)
  };
  // -----------------------------------------------------------------
  // frame format
  // -----------------------------------------------------------------
  localparam int          DATA_BITS   = 8;
  localparam int          STOP_BITS   = 1;
  localparam logic [7:0]  SYNC_BYTE   = 8'h1c;
  localparam logic [7:0]  ACK_BYTE    = 8'h55;
  // welcome text sent after lock, ending in a carriage return
  localparam int          MSG_LEN     = 10;
  localparam logic [7:0]  MSG_TEXT [MSG_LEN] = '{
    8'h0d, 8'h0a, 8'h57, 8'h45, 8'h4c, 8'h43, 8'h4f, 8'h4d, 8'h45, 8'h0d
  };
  // -----------------------------------------------------------------
  // handshake states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_MEASURE = 3'b000,
    ST_SAMPLE  = 3'b001,
    ST_ACK     = 3'b010,
    ST_ECHO    = 3'b011,
    ST_WELCOME = 3'b100,
    ST_LOCKED  = 3'b101
  } arh_state_type;
endpackage

/* File: verilog/arh_uart_tx.sv */
// file: 8n1 serial transmitter with run-time bit period
`timescale 1ns/1ps
module arh_uart_tx (
  input  wire logic                     ref_clk,   // system clock
  input  wire logic                     rst_n,     // sync reset, active low
  input  wire logic [arh_pkg::DIV_W-1:0] bit_div,  // cycles per bit
  input  wire logic                     tx_valid,  // byte offered
  input  wire logic [7:0]               tx_data,   // byte to send
  output logic                          tx_ready,  // idle, byte taken
  output logic                          txd        // serial line out
);
  typedef struct packed {
    logic                      busy;
    logic [9:0]                shreg;
    logic [3:0]                nbit;
    logic [arh_pkg::DIV_W-1:0] cnt;
  } arh_tx_type;
  arh_tx_type s_q, s_d;

  assign tx_ready = !s_q.busy;
  assign txd      = s_q.shreg[0];

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (tx_valid) begin
        // start bit, eight data bits, one stop bit, no parity
        s_d.shreg = {1'b1, tx_data, 1'b0};
        s_d.busy  = 1'b1;
        s_d.nbit  = 4'h0;
        s_d.cnt   = bit_div - 16'h0001;
      end
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end else if (s_q.nbit == 4'h9) begin
      s_d.busy = 1'b0;
    end else begin
      s_d.shreg = {1'b1, s_q.shreg[9:1]};
      s_d.nbit  = s_q.nbit + 4'h1;
      s_d.cnt   = bit_div - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '{busy: 1'b0, shreg: 10'h3ff, nbit: 4'h0, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule // arh_uart_tx

/* File: verilog/arh_auto_rate_handshake.sv */
// file: automatic rate detection handshake for the host serial port
//
// Behaviour
// - only 9600 to 921600 bps in the eight standard steps are used
// - frames are 8 data bits, no parity, 1 stop bit, no flow control
// - rate is found from the host's byte exchange, no configuration written
// - on sync, reply acknowledge 0x55 at the same detected rate
// - on the echoed 0x55, lock the detected rate for all later traffic
// - the exchange is always performed, it cannot be bypassed
// - after lock, send a welcome message
`timescale 1ns/1ps
module arh_auto_rate_handshake (
  input  wire logic       ref_clk,      // 100 mhz system clock
  input  wire logic       rst_n,        // sync reset, active low
  input  wire logic       rxd,          // serial line from host
  output logic            txd,          // serial line to host
  output logic            rate_locked,  // rate fixed, handshake done
  output logic [2:0]      rate_index,   // 0 = 9600 ... 7 = 921600
  output logic            rx_valid,     // one-cycle pulse, byte after lock
  output logic [7:0]      rx_data,      // received byte after lock
  input  wire logic       tx_valid,     // user byte offered after lock
  input  wire logic [7:0] tx_data,      // user byte
  output logic            tx_ready      // user byte taken when high
);
  localparam int DW = arh_pkg::DIV_W;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic                    rx_s1;
    logic                    rx_s2;
    logic                    rx_prev;
    arh_pkg::arh_state_type  st;
    logic [19:0]             meas;     // low-time count while measuring
    logic [2:0]              idx;
    logic [DW-1:0]           cnt;
    logic [3:0]              nbit;
    logic [7:0]              shreg;
    logic                    rx_busy;
    logic [3:0]              msg_pos;
    logic                    out_valid;
    logic [7:0]              out_data;
  } arh_main_type;
  arh_main_type s_q, s_d;

  logic          ut_valid;
  logic [7:0]    ut_data;
  logic          ut_ready;
  logic [DW-1:0] cur_div;
  logic          byte_done;
  logic [2:0]    snap_idx;

  // -----------------------------------------------------------------
  // rate and state decoding
  // -----------------------------------------------------------------
  // limitation: the rate comes from a single low run, so a host clock off
  // by more than a few percent may land on a neighbouring step or
  // mis-sample the last data bits; traded for a detector with no long
  // averaging counter
  // nearest supported rate by midpoints between neighbouring bit times
  function automatic logic [2:0] arh_snap(input logic [19:0] t);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 1; i < arh_pkg::NUM_RATES; i++) begin
      if (t < 20'((32'(arh_pkg::RATE_DIV[i-1]) + 32'(arh_pkg::RATE_DIV[i])) / 2)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // states in which the shared receiver owns the synchronised line
  function automatic logic arh_rx_on(input arh_pkg::arh_state_type st);
    return (st == arh_pkg::ST_SAMPLE) || (st == arh_pkg::ST_ECHO) ||
           (st == arh_pkg::ST_LOCKED);
  endfunction

  assign cur_div   = arh_pkg::RATE_DIV[s_q.idx];
  assign byte_done = s_q.rx_busy && (s_q.cnt == '0) && (s_q.nbit == 4'h9);
  assign snap_idx  = arh_snap(20'(s_q.meas / 3));

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.rx_s1     = rxd;
    s_d.rx_s2     = s_q.rx_s1;
    s_d.rx_prev   = s_q.rx_s2;
    s_d.out_valid = 1'b0;
    ut_valid      = 1'b0;
    ut_data       = arh_pkg::ACK_BYTE;

    // sync 0x1c starts with start bit plus two zero data bits: the first
    // low run is three bit times, which measures the rate by itself
    case (s_q.st)
      arh_pkg::ST_MEASURE: begin
        if (!s_q.rx_s2) begin
          // saturate: a line stuck low must not wrap into a short, fast-looking run
          if (s_q.meas != 20'hfffff) begin
            s_d.meas = s_q.meas + 20'h00001;
          end
        end else if (s_q.rx_prev == 1'b0 && s_q.meas != '0) begin
          s_d.idx  = snap_idx;
          s_d.meas = '0;
          // resume mid bit 2 of the sync byte and collect the rest
          s_d.st      = arh_pkg::ST_SAMPLE;
          s_d.rx_busy = 1'b1;
          s_d.nbit    = 4'h3;
          s_d.shreg   = 8'h00;
          s_d.cnt     = DW'(arh_pkg::RATE_DIV[snap_idx] / 2);
        end
      end
      arh_pkg::ST_SAMPLE, arh_pkg::ST_ECHO: begin
        if (byte_done) begin
          s_d.rx_busy = 1'b0;
          if (s_q.st == arh_pkg::ST_SAMPLE) begin
            // only a clean sync byte is answered, others restart detection
            s_d.st = (s_q.shreg == arh_pkg::SYNC_BYTE && s_q.rx_s2)
                     ? arh_pkg::ST_ACK : arh_pkg::ST_MEASURE;
          end else if (s_q.shreg == arh_pkg::ACK_BYTE && s_q.rx_s2) begin
            s_d.st      = arh_pkg::ST_WELCOME;
            s_d.msg_pos = 4'h0;
          end else begin
            s_d.st = arh_pkg::ST_MEASURE; // a retried sync is measured afresh
          end
        end
      end
      arh_pkg::ST_ACK: begin
        // the transmitter idles here, so the reply leaves within one cycle
        ut_valid = 1'b1;
        ut_data  = arh_pkg::ACK_BYTE;
        if (ut_ready) begin
          s_d.st = arh_pkg::ST_ECHO;
        end
      end
      arh_pkg::ST_WELCOME: begin
        // lock shows once the last welcome byte is taken, not when it ends
        ut_valid = 1'b1;
        ut_data  = arh_pkg::MSG_TEXT[s_q.msg_pos];
        if (ut_ready) begin
          if (s_q.msg_pos == 4'(arh_pkg::MSG_LEN - 1)) begin
            s_d.st = arh_pkg::ST_LOCKED;
          end else begin
            s_d.msg_pos = s_q.msg_pos + 4'h1;
          end
        end
      end
      arh_pkg::ST_LOCKED: begin
        ut_valid = tx_valid;
        ut_data  = tx_data;
        // a bad stop bit drops the byte; there is no framing error flag
        if (byte_done) begin
          s_d.rx_busy   = 1'b0;
          s_d.out_valid = s_q.rx_s2; // stop bit must be high
          s_d.out_data  = s_q.shreg;
        end
      end
      default: begin
        s_d.st = arh_pkg::ST_MEASURE;
      end
    endcase

    // shared receiver for sync, echo and locked phases, at the detected rate
    if (arh_rx_on(s_q.st)) begin
      if (!s_q.rx_busy) begin
        if (s_q.st != arh_pkg::ST_SAMPLE && s_q.rx_prev && !s_q.rx_s2) begin
          s_d.rx_busy = 1'b1;
          s_d.nbit    = 4'h0;
          s_d.cnt     = DW'(cur_div / 2);
        end
      end else if (s_q.cnt != '0) begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end else if (s_q.nbit == 4'h0) begin
        // false start bit is dropped
        s_d.rx_busy = !s_q.rx_s2;
        s_d.nbit    = 4'h1;
        s_d.cnt     = cur_div - 16'h0001;
      end else if (s_q.nbit != 4'h9) begin
        s_d.shreg = {s_q.rx_s2, s_q.shreg[7:1]};
        s_d.nbit  = s_q.nbit + 4'h1;
        s_d.cnt   = cur_div - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // line synchroniser resets to the idle level so no false edge follows
      s_q <= '{rx_s1: 1'b1, rx_s2: 1'b1, rx_prev: 1'b1, st: arh_pkg::ST_MEASURE,
               meas: '0, idx: 3'h0, cnt: '0, nbit: 4'h0, shreg: 8'h00,
               rx_busy: 1'b0, msg_pos: 4'h0, out_valid: 1'b0, out_data: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // transmitter and outputs
  // -----------------------------------------------------------------
  arh_uart_tx u_tx (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .bit_div  (cur_div),
    .tx_valid (ut_valid),
    .tx_data  (ut_data),
    .tx_ready (ut_ready),
    .txd      (txd)
  );

  // user bytes are refused until the handshake has fixed the rate
  assign tx_ready    = (s_q.st == arh_pkg::ST_LOCKED) && ut_ready;
  assign rate_locked = (s_q.st == arh_pkg::ST_LOCKED);
  assign rate_index  = s_q.idx;
  assign rx_valid    = s_q.out_valid;
  assign rx_data     = s_q.out_data;
endmodule // arh_auto_rate_handshake

/* File: test/arh_hs_sva.sv */
// port assertions for the rate handshake block
`timescale 1ns/1ps
module arh_hs_sva (
  input wire logic       ref_clk,     // clock
  input wire logic       rst_n,       // sync reset
  input wire logic       txd,         // serial out
  input wire logic       rate_locked, // rate fixed
  input wire logic [2:0] rate_index,  // detected rate
  input wire logic       rx_valid,    // byte pulse
  input wire logic       tx_valid,    // user offer
  input wire logic       tx_ready     // user taken
);
  // ------
  // low run of txd, must span whole bit times
  // ------
  // wide enough for nine low bits at the slowest rate
  struct packed {logic [19:0] low_cnt;} h_q, h_d;
  always_comb begin
    h_d = h_q;
    h_d.low_cnt = txd ? 20'h0 : h_q.low_cnt + 20'h1;
  end
  always_ff @(posedge ref_clk) begin
    h_q <= rst_n ? h_d : '0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rst_vals_a: assert property ($rose(rst_n) |->
    txd && !rate_locked && !tx_ready && !rx_valid && rate_index == 3'h0)
    else $error("outputs not at reset values");
  tx_gate_a: assert property (!rate_locked |-> !tx_ready)
    else $error("user byte taken before lock");
  rx_gate_a: assert property (!rate_locked |-> !rx_valid)
    else $error("byte delivered before lock");
  lock_holds_a: assert property (rate_locked |=> rate_locked)
    else $error("lock dropped");
  rate_fixed_a: assert property (rate_locked |=> $stable(rate_index))
    else $error("rate changed after lock");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("byte pulse longer than one cycle");
  take_busy_a: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("ready after byte taken");
  take_start_a: assert property (tx_valid && tx_ready |-> ##[1:3] !txd)
    else $error("no start bit after byte taken");
  bit_time_a: assert property ($rose(txd) && rate_locked |->
    (h_q.low_cnt % arh_pkg::RATE_DIV[rate_index]) == 20'h0)
    else $error("low run not whole bit times");
endmodule // arh_hs_sva

bind arh_auto_rate_handshake arh_hs_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .txd(txd),
  .rate_locked(rate_locked), .rate_index(rate_index), .rx_valid(rx_valid),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

/* File: test/arh_host_model.sv */
// host serial port model: sends 8n1 bytes, decodes the module's replies
`timescale 1ns/1ps
module arh_host_model (
  input  wire logic        ref_clk,  // clock
  input  wire logic [15:0] bit_div,  // cycles per bit, set before reset
  input  wire logic        txd,      // module serial out
  output logic             rxd,      // host serial out
  output logic             got,      // pulse per decoded byte
  output logic [8:0]       got_byte  // stop bit and data
);
  logic [8:0] sh;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_byte = 9'h0;
  end
  // gap makes a slow host; line idles high meanwhile
  task automatic send_byte(input logic [7:0] v, input int gap);
    logic [9:0] fr;
    fr = {1'b1, v, 1'b0};
    repeat (gap) @(negedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      rxd = fr[i];
      repeat (bit_div) @(negedge ref_clk);
    end
  endtask
  always begin
    @(negedge txd);
    repeat (bit_div / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_div) @(posedge ref_clk);
      sh[i] = txd;
    end
    got_byte <= sh;
    got <= 1'b1;
    @(posedge ref_clk);
    got <= 1'b0;
  end
endmodule // arh_host_model

/* File: test/tb_top.sv */
// testbench: rate handshake at two rates, then locked traffic both ways
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, rst_n, rxd, txd, rate_locked, rx_valid, tx_valid, tx_ready, got;
  logic [2:0]  rate_index;
  logic [7:0]  tx_data, rx_data, b;
  logic [8:0]  got_byte;
  logic [15:0] div;
  logic [8:0]  tx_exp[$];
  logic [7:0]  rx_exp[$];
  int          failures, compares, n;
  arh_auto_rate_handshake DUT (.ref_clk(ref_clk), .rst_n(rst_n), .rxd(rxd), .txd(txd),
    .rate_locked(rate_locked), .rate_index(rate_index), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  arh_host_model host (.ref_clk(ref_clk), .bit_div(div), .txd(txd), .rxd(rxd), .got(got),
    .got_byte(got_byte));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic drain();
    n = 0;
    while (tx_exp.size() + rx_exp.size() != 0 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 60000) begin
      failures++;
    end
  endtask
  task automatic send_user(input logic [7:0] v);
    tx_exp.push_back({1'b1, v});
    n = 0;
    while (tx_ready !== 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 60000) begin
      failures++;
    end
    tx_data = v;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask
  // ------
  // result watchers
  // ------
  always @(posedge ref_clk) begin
    if (got === 1'b1 && tx_exp.size() == 0) check(got_byte, 9'bx, "stray txd byte");
    else if (got === 1'b1) check(got_byte, tx_exp.pop_front(), "txd byte");
    if (rx_valid === 1'b1 && rx_exp.size() == 0) check({1'b0, rx_data}, 9'bx, "stray rx");
    else if (rx_valid === 1'b1) check({1'b0, rx_data}, {1'b0, rx_exp.pop_front()}, "rx");
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    failures++;
    final_report();
  end
  // ------
  // main sequence
  // ------
  initial begin
    rst_n = 1'b0;
    tx_valid = 1'b1;
    tx_data = 8'ha5;
    div = arh_pkg::RATE_DIV[7];
    void'($urandom(32'h4ee2));
    for (int r = 0; r < 2; r++) begin
      @(negedge ref_clk);
      rst_n = 1'b0;
      tx_valid = 1'b1;
      div = arh_pkg::RATE_DIV[7-r];
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      host.send_byte(8'h3c, 20);
      repeat (12 * div) @(negedge ref_clk);
      tx_exp.push_back({1'b1, arh_pkg::ACK_BYTE});
      host.send_byte(arh_pkg::SYNC_BYTE, 0);
      drain();
      check({8'h00, rate_locked}, 9'h000, "early rate_locked");
      // wrong echo sends the block back to detection
      host.send_byte(8'haa, 0);
      repeat (12 * div) @(negedge ref_clk);
      tx_exp.push_back({1'b1, arh_pkg::ACK_BYTE});
      host.send_byte(arh_pkg::SYNC_BYTE, 0);
      drain();
      for (int i = 0; i < arh_pkg::MSG_LEN; i++) begin
        tx_exp.push_back({1'b1, arh_pkg::MSG_TEXT[i]});
      end
      host.send_byte(arh_pkg::ACK_BYTE, r * 3000);
      n = 0;
      while (rate_locked !== 1'b1 && n < 40000) begin
        @(negedge ref_clk);
        n++;
      end
      tx_valid = 1'b0;
      check({8'h00, rate_locked}, 9'h001, "rate_locked");
      check({6'h0, rate_index}, 9'(7 - r), "rate_index");
      for (int i = 0; i < 3; i++) begin
        b = 8'($urandom());
        rx_exp.push_back(b);
        host.send_byte(b, 0);
        send_user(8'($urandom()));
      end
      drain();
    end
    final_report();
  end
endmodule // tb_top
